// >>> rtl/pfcec_pkg.sv
/*
 * Package for the parallel flash command and erase controller.
 * Holds register offsets, field positions, command codes and pin timing counts.
 * Assumes a 50 MHz system clock.
 */
package pfcec_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 20;
   localparam int RST_LOW_NS       = 500;
   localparam int RST_LOW_CYC      = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_NS         = 80;
   localparam int PULSE_CYC        = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_NS        = 100;
   localparam int ACCESS_CYC       = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC        = 1;
   localparam int CNT_W            = 8;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h4;
   localparam logic [3:0] REG_WDATA  = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;

   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   localparam int CTRL_OP_LSB      = 0;
   localparam int CTRL_OP_W        = 4;
   localparam int CTRL_WORD_BIT    = 4;
   localparam int CTRL_VPP_BIT     = 5;
   localparam int CTRL_GO_BIT      = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0010;

   // ---------------------------------------------------------------
   // Status fields
   // ---------------------------------------------------------------
   localparam int STAT_BUSY_BIT    = 16;
   localparam int STAT_RDY_BIT     = 17;
   localparam int STAT_SPM_BIT     = 18;

   // ---------------------------------------------------------------
   // Operations
   // ---------------------------------------------------------------
   localparam logic [3:0] OP_READ        = 4'h0;
   localparam logic [3:0] OP_PROGRAM     = 4'h1;
   localparam logic [3:0] OP_CHIP_ERASE  = 4'h2;
   localparam logic [3:0] OP_SECT_ERASE  = 4'h3;
   localparam logic [3:0] OP_SPM_ENTER   = 4'h4;
   localparam logic [3:0] OP_SPM_WRITE   = 4'h5;
   localparam logic [3:0] OP_RESET       = 4'h6;
   localparam logic [3:0] OP_SUSPEND     = 4'h7;
   localparam logic [3:0] OP_RESUME      = 4'h8;
   localparam logic [3:0] OP_RAW_WRITE   = 4'h9;

   // ---------------------------------------------------------------
   // Command bus cycles
   // ---------------------------------------------------------------
   localparam logic [19:0] UNLOCK_A1  = 20'h00555;
   localparam logic [19:0] UNLOCK_A2  = 20'h00aaa;
   localparam logic [7:0]  CODE_AA    = 8'haa;
   localparam logic [7:0]  CODE_55    = 8'h55;
   localparam logic [7:0]  CODE_PROG  = 8'ha0;
   localparam logic [7:0]  CODE_ERASE = 8'h80;
   localparam logic [7:0]  CODE_CHIP  = 8'h10;
   localparam logic [7:0]  CODE_SECT  = 8'h30;
   localparam logic [7:0]  CODE_SPM1  = 8'h80;
   localparam logic [7:0]  CODE_SPM2  = 8'ha0;
   localparam logic [7:0]  CODE_SUSP  = 8'hb0;
   localparam logic [7:0]  CODE_RESM  = 8'hd0;
   localparam int          SEQ_MAX    = 6;

   typedef enum logic [1:0] {
      PFCEC_CYC_WRITE,
      PFCEC_CYC_READ
   } pfcec_cyc_t;

endpackage : pfcec_pkg

// >>> rtl/pfcec_cyc_if.sv
/*
 * Interface between the sequencer and the bus cycle engine.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
interface pfcec_cyc_if;
   import pfcec_pkg::*;
   logic             req;
   pfcec_cyc_t       kind;
   logic [19:0]      addr;
   logic             lsb;
   logic [15:0]      wdata;
   logic             done;
   logic [15:0]      rdata;

   modport seq (output req, kind, addr, lsb, wdata, input done, rdata);
   modport eng (input req, kind, addr, lsb, wdata, output done, rdata);
endinterface : pfcec_cyc_if

// >>> rtl/pfcec_cyc_eng.sv
/*
 * Bus cycle engine: one read or one write cycle on the flash pins.
 * Assumes the flash data pins come back through a two-flop synchroniser.
 */
`timescale 1ns/100ps
module pfcec_cyc_eng
   import pfcec_pkg::*;
(
   // Clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_rst,
   // Sequencer side
   pfcec_cyc_if.eng          cyc,
   // Width select
   input  wire logic         i_word,
   // Synchronised data in
   input  wire logic [15:0]  i_dq_sync,
   // Flash pins
   output logic [19:0]       o_addr,
   output logic              o_ce_n,
   output logic              o_oe_n,
   output logic              o_we_n,
   output logic [15:0]       o_dq,
   output logic [15:0]       o_dq_oe
);
   typedef enum logic [1:0] {PFCEC_E_IDLE, PFCEC_E_SETUP, PFCEC_E_PULSE, PFCEC_E_HOLD} pfcec_est_t;

   pfcec_est_t         st_q, st_d;
   logic [CNT_W-1:0]   cnt_q, cnt_d;
   logic [19:0]        addr_q, addr_d;
   logic               ce_q, ce_d, oe_q, oe_d, we_q, we_d, drv_q, drv_d, lsb_q, lsb_d;
   logic [15:0]        wd_q, wd_d, rd_q, rd_d;
   logic               done_q, done_d;

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      addr_d = addr_q;
      ce_d   = ce_q;
      oe_d   = oe_q;
      we_d   = we_q;
      drv_d  = drv_q;
      lsb_d  = lsb_q;
      wd_d   = wd_q;
      rd_d   = rd_q;
      done_d = 1'b0;
      case (st_q)
         PFCEC_E_IDLE: begin
            if (cyc.req && !done_q) begin
               addr_d = cyc.addr;
               lsb_d  = cyc.lsb;
               wd_d   = cyc.wdata;
               drv_d  = (cyc.kind == PFCEC_CYC_WRITE);
               cnt_d  = CNT_W'(SETUP_CYC);
               st_d   = PFCEC_E_SETUP;
            end
         end
         PFCEC_E_SETUP: begin
            if (cnt_q <= 1) begin
               ce_d  = 1'b1;
               // Write strobes with output enable high; read keeps write strobe high
               we_d  = drv_q;
               oe_d  = !drv_q;
               cnt_d = CNT_W'(drv_q ? PULSE_CYC : ACCESS_CYC);
               st_d  = PFCEC_E_PULSE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         PFCEC_E_PULSE: begin
            if (cnt_q <= 1) begin
               ce_d  = 1'b0;
               we_d  = 1'b0;
               oe_d  = 1'b0;
               rd_d  = i_dq_sync;
               st_d  = PFCEC_E_HOLD;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         PFCEC_E_HOLD: begin
            drv_d  = 1'b0;
            done_d = 1'b1;
            st_d   = PFCEC_E_IDLE;
         end
         default: st_d = PFCEC_E_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         st_q <= PFCEC_E_IDLE;
         cnt_q <= '0;
         addr_q <= '0;
         ce_q <= 1'b0;
         oe_q <= 1'b0;
         we_q <= 1'b0;
         drv_q <= 1'b0;
         lsb_q <= 1'b0;
         wd_q <= '0;
         rd_q <= '0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         ce_q <= ce_d;
         oe_q <= oe_d;
         we_q <= we_d;
         drv_q <= drv_d;
         lsb_q <= lsb_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         done_q <= done_d;
      end
   end

   // Byte mode: pin 15 carries the byte address and 8 to 14 stay released
   assign o_addr     = addr_q;
   assign o_ce_n     = !ce_q;
   assign o_oe_n     = !oe_q;
   assign o_we_n     = !we_q;
   assign o_dq       = i_word ? wd_q : {lsb_q, 7'h00, wd_q[7:0]};
   assign o_dq_oe    = i_word ? {16{drv_q}} : {1'b1, 7'h00, {8{drv_q}}};
   assign cyc.done   = done_q;
   assign cyc.rdata  = i_word ? rd_q : {8'h00, rd_q[7:0]};
endmodule : pfcec_cyc_eng

// >>> rtl/pfcec_top.sv
/*
 * Host controller for an asynchronous parallel NOR flash: read, program,
 * chip and sector erase, single-pulse program mode, suspend/resume and reset.
 * Assumes an Avalon-MM master with waitrequest and a flash wired to the pins.
 */
`timescale 1ns/100ps
module pfcec_top
   import pfcec_pkg::*;
(
   // Clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_rst,
   // Avalon-MM slave
   input  wire logic [3:0]   i_avs_address,
   input  wire logic         i_avs_read,
   input  wire logic         i_avs_write,
   input  wire logic [31:0]  i_avs_writedata,
   output logic [31:0]       o_avs_readdata,
   output logic              o_avs_waitrequest,
   // Flash pins
   output logic [19:0]       o_fl_addr,
   output logic              o_fl_ce_n,
   output logic              o_fl_oe_n,
   output logic              o_fl_we_n,
   output logic              o_fl_reset_n,
   output logic              o_fl_word,
   output logic              o_fl_vpp_en,
   output logic [15:0]       o_fl_dq,
   output logic [15:0]       o_fl_dq_oe,
   input  wire logic [15:0]  i_fl_dq,
   input  wire logic         i_fl_ready
);
   typedef enum logic [1:0] {PFCEC_IDLE, PFCEC_CYC, PFCEC_RST} pfcec_st_t;

   pfcec_cyc_if cyc();

   pfcec_st_t          st_q, st_d;
   logic [3:0]         op_q, op_d;
   logic [2:0]         idx_q, idx_d;
   logic [CNT_W-1:0]   cnt_q, cnt_d;
   logic               word_q, word_d, vpp_q, vpp_d, spm_q, spm_d, rstn_q, rstn_d;
   logic [20:0]        addr_q, addr_d;
   logic [15:0]        wdat_q, wdat_d, rdat_q, rdat_d;
   logic [15:0]        dq_s1_q, dq_s2_q;
   logic               rdy_s1_q, rdy_s2_q;
   logic [2:0]         nseq;
   logic [19:0]        seq_a;
   logic [7:0]         seq_c;
   logic               seq_data;

   // ---------------------------------------------------------------
   // Command table
   // ---------------------------------------------------------------
   function automatic logic [2:0] seq_len(input logic [3:0] op);
      case (op)
         OP_PROGRAM:    seq_len = 3'd4;
         OP_CHIP_ERASE: seq_len = 3'd6;
         OP_SECT_ERASE: seq_len = 3'd6;
         OP_SPM_ENTER:  seq_len = 3'd6;
         default:       seq_len = 3'd1;
      endcase
   endfunction : seq_len

   always_comb begin
      nseq     = seq_len(op_q);
      seq_data = 1'b0;
      seq_a    = UNLOCK_A1;
      seq_c    = CODE_AA;
      case (idx_q)
         3'd1: begin
            seq_a = UNLOCK_A2;
            seq_c = CODE_55;
         end
         3'd2: seq_c = (op_q == OP_PROGRAM) ? CODE_PROG : CODE_ERASE;
         3'd4: begin
            seq_a = UNLOCK_A2;
            seq_c = CODE_55;
         end
         3'd5: seq_c = (op_q == OP_CHIP_ERASE) ? CODE_CHIP : (op_q == OP_SPM_ENTER) ? CODE_SPM2 : CODE_SECT;
         default: seq_c = CODE_AA;
      endcase
      // Last cycle of program, sector erase and single-pulse writes carries user address
      if (idx_q == nseq - 3'd1 && (op_q == OP_PROGRAM || op_q == OP_SECT_ERASE ||
                                   op_q == OP_SPM_WRITE || op_q == OP_RAW_WRITE || op_q == OP_READ))
         seq_data = 1'b1;
      if (op_q == OP_SUSPEND)
         seq_c = CODE_SUSP;
      if (op_q == OP_RESUME)
         seq_c = CODE_RESM;
   end

   // Width: byte mode moves address LSB onto pin 15
   assign cyc.req   = (st_q == PFCEC_CYC);
   assign cyc.kind  = (op_q == OP_READ) ? PFCEC_CYC_READ : PFCEC_CYC_WRITE;
   assign cyc.addr  = seq_data ? (word_q ? addr_q[19:0] : addr_q[20:1]) : seq_a;
   assign cyc.lsb   = word_q ? 1'b0 : addr_q[0];
   assign cyc.wdata = (seq_data && op_q != OP_SECT_ERASE) ? wdat_q : {8'h00, seq_c};

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      st_d   = st_q;
      op_d   = op_q;
      idx_d  = idx_q;
      cnt_d  = cnt_q;
      word_d = word_q;
      vpp_d  = vpp_q;
      spm_d  = spm_q;
      rstn_d = rstn_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      rdat_d = rdat_q;
      if (i_avs_write && st_q == PFCEC_IDLE) begin
         case (i_avs_address)
            REG_ADDR:  addr_d = i_avs_writedata[20:0];
            REG_WDATA: wdat_d = i_avs_writedata[15:0];
            REG_CTRL: begin
               word_d = i_avs_writedata[CTRL_WORD_BIT];
               vpp_d  = i_avs_writedata[CTRL_VPP_BIT];
               if (i_avs_writedata[CTRL_GO_BIT]) begin
                  op_d  = i_avs_writedata[CTRL_OP_LSB +: CTRL_OP_W];
                  idx_d = '0;
                  st_d  = PFCEC_CYC;
                  // In single-pulse mode any write request is a lone data pulse
                  if (spm_q && i_avs_writedata[CTRL_OP_LSB +: CTRL_OP_W] != OP_READ &&
                      i_avs_writedata[CTRL_OP_LSB +: CTRL_OP_W] != OP_RESET)
                     op_d = OP_SPM_WRITE;
                  if (i_avs_writedata[CTRL_OP_LSB +: CTRL_OP_W] == OP_RESET) begin
                     rstn_d = 1'b0;
                     cnt_d  = CNT_W'(RST_LOW_CYC);
                     st_d   = PFCEC_RST;
                  end
               end
            end
            default: ;
         endcase
      end
      case (st_q)
         PFCEC_CYC: begin
            if (cyc.done) begin
               if (op_q == OP_READ)
                  rdat_d = cyc.rdata;
               if (idx_q == nseq - 3'd1) begin
                  if (op_q == OP_SPM_ENTER)
                     spm_d = 1'b1;
                  st_d = PFCEC_IDLE;
               end else begin
                  idx_d = idx_q + 3'd1;
               end
            end
         end
         PFCEC_RST: begin
            // Reset held at least 500 ns, then released; leaves single-pulse mode
            if (cnt_q <= 1) begin
               rstn_d = 1'b1;
               spm_d  = 1'b0;
               st_d   = PFCEC_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         st_q     <= PFCEC_IDLE;
         op_q     <= OP_READ;
         idx_q    <= '0;
         cnt_q    <= '0;
         word_q   <= CTRL_RST[CTRL_WORD_BIT];
         vpp_q    <= CTRL_RST[CTRL_VPP_BIT];
         spm_q    <= 1'b0;
         rstn_q   <= 1'b1;
         addr_q   <= '0;
         wdat_q   <= '0;
         rdat_q   <= '0;
         dq_s1_q  <= '0;
         dq_s2_q  <= '0;
         rdy_s1_q <= 1'b0;
         rdy_s2_q <= 1'b0;
      end else begin
         st_q     <= st_d;
         op_q     <= op_d;
         idx_q    <= idx_d;
         cnt_q    <= cnt_d;
         word_q   <= word_d;
         vpp_q    <= vpp_d;
         spm_q    <= spm_d;
         rstn_q   <= rstn_d;
         addr_q   <= addr_d;
         wdat_q   <= wdat_d;
         rdat_q   <= rdat_d;
         dq_s1_q  <= i_fl_dq;
         dq_s2_q  <= dq_s1_q;
         rdy_s1_q <= i_fl_ready;
         rdy_s2_q <= rdy_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // Bus cycle engine
   // ---------------------------------------------------------------
   pfcec_cyc_eng u_eng (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .cyc       (cyc),
      .i_word    (word_q),
      .i_dq_sync (dq_s2_q),
      .o_addr    (o_fl_addr),
      .o_ce_n    (o_fl_ce_n),
      .o_oe_n    (o_fl_oe_n),
      .o_we_n    (o_fl_we_n),
      .o_dq      (o_fl_dq),
      .o_dq_oe   (o_fl_dq_oe)
   );

   assign o_fl_reset_n = rstn_q;
   assign o_fl_word    = word_q;
   assign o_fl_vpp_en  = vpp_q;

   // ---------------------------------------------------------------
   // Register read
   // ---------------------------------------------------------------
   assign o_avs_waitrequest = 1'b0;
   always_comb begin
      o_avs_readdata = 32'h0000_0000;
      case (i_avs_address)
         REG_CTRL:   o_avs_readdata = {23'h0, 1'b0, 2'b00, vpp_q, word_q, op_q};
         REG_ADDR:   o_avs_readdata = {11'h0, addr_q};
         REG_WDATA:  o_avs_readdata = {16'h0, wdat_q};
         REG_STATUS: begin
            o_avs_readdata[15:0]          = rdat_q;
            o_avs_readdata[STAT_BUSY_BIT] = (st_q != PFCEC_IDLE);
            o_avs_readdata[STAT_RDY_BIT]  = rdy_s2_q;
            o_avs_readdata[STAT_SPM_BIT]  = spm_q;
         end
         default: ;
      endcase
   end
endmodule : pfcec_top

// >>> tb/pfcec_flash_model.sv
/*
 * Behavioural model of the parallel NOR flash on the controller's pins.
 * Assumes the bench resolves the data bus from the controller's enables alone.
 */
`timescale 1ns/100ps
module pfcec_flash_model
   import pfcec_pkg::*;
(
   // Flash pins
   input  wire logic [19:0] i_addr,
   input  wire logic        i_ce_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   input  wire logic        i_reset_n,
   input  wire logic        i_word,
   input  wire logic        i_vpp_en,
   input  wire logic [15:0] i_dq,
   output logic [15:0]      o_dq,
   output logic [15:0]      o_dq_oe,
   output logic             o_ready
);
   localparam int LOCK_SECT = 38; // Sector the model never erases
   logic [15:0] mem [int];
   logic [15:0] rd;
   logic [15:0] last_q;
   logic [19:0] a_q;
   logic        on_q;
   logic        spm_q;
   logic        susp_q;
   int          n_q;
   realtime     t_low;

   function automatic int sect(input logic [19:0] a);
      return (a[19:15] == 5'h00) ? int'(a[14:12]) : int'(a[19:15]) + 7;
   endfunction : sect

   task automatic prog(input logic [19:0] a, input logic [15:0] d);
      if (i_vpp_en) begin
         mem[int'(a)] = (mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff) & d;
         o_ready = 1'b0;
         o_ready <= #400 1'b1;
      end
   endtask : prog

   task automatic erase(input int s);
      if (i_vpp_en) begin
         foreach (mem[k])
            if ((s < 0 || sect(20'(k)) == s) && sect(20'(k)) != LOCK_SECT) mem[k] = 16'hffff;
         o_ready = 1'b0;
         o_ready <= #400 1'b1;
      end
   endtask : erase

   task automatic wr_cyc(input logic [19:0] a, input logic [7:0] c, input logic [15:0] d);
      if (!o_ready) return;
      if (spm_q || n_q == 9) begin
         prog(a, d);
         n_q = 0;
      end else if (n_q == 0 && (c == CODE_SUSP || c == CODE_RESM)) begin
         susp_q = (c == CODE_SUSP);
      end else begin
         case (n_q)
            0, 3: n_q = (c == CODE_AA && a == UNLOCK_A1) ? n_q + 1 : 0;
            1, 4: n_q = (c == CODE_55 && a == UNLOCK_A2) ? n_q + 1 : 0;
            2: n_q = (c == CODE_PROG) ? 9 : (c == CODE_ERASE) ? 3 : 0;
            default: begin
               if (c == CODE_CHIP) erase(-1);
               else if (c == CODE_SECT) erase(sect(a));
               else if (c == CODE_SPM2) spm_q = 1'b1;
               n_q = 0;
            end
         endcase
      end
   endtask : wr_cyc

   initial begin
      n_q = 0;
      on_q = 1'b0;
      spm_q = 1'b0;
      susp_q = 1'b0;
      o_ready = 1'b1;
      last_q = 16'h0000;
      t_low = 0;
   end

   always @* begin
      rd = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 16'hffff;
      if (!i_word) rd = {8'h00, i_dq[15] ? rd[15:8] : rd[7:0]};
   end
   // Floating lines show the inverse of the last driven value
   assign o_dq_oe = (i_ce_n || i_oe_n || !i_we_n || !i_reset_n) ? 16'h0000 :
                    i_word ? 16'hffff : 16'h00ff;
   always @* if (o_dq_oe[0]) last_q = rd;
   assign o_dq = (o_dq_oe & rd) | (~o_dq_oe & ~last_q);

   always @(negedge i_we_n or negedge i_ce_n) begin
      if (!i_we_n && !i_ce_n && i_oe_n && i_reset_n) begin
         a_q = i_addr;
         on_q = 1'b1;
      end
   end
   always @(posedge i_we_n or posedge i_ce_n) begin
      if (on_q) begin
         on_q = 1'b0;
         wr_cyc(a_q, i_dq[7:0], i_dq);
      end
   end
   always @(negedge i_reset_n) begin
      t_low = $realtime;
      n_q = 0;
      on_q = 1'b0;
      o_ready = 1'b1;
   end
   always @(posedge i_reset_n) if ($realtime - t_low >= 500.0) spm_q = 1'b0;
endmodule : pfcec_flash_model

// >>> tb/pfcec_top_properties.sv
/*
 * Pin protocol assertions for the flash controller.
 * Assumes binding onto the controller's top module.
 */
`timescale 1ns/100ps
module pfcec_top_properties
   import pfcec_pkg::*;
(
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   input wire logic [19:0] o_fl_addr,
   input wire logic        o_fl_ce_n,
   input wire logic        o_fl_oe_n,
   input wire logic        o_fl_we_n,
   input wire logic        o_fl_reset_n,
   input wire logic        o_fl_word,
   input wire logic [15:0] o_fl_dq,
   input wire logic [15:0] o_fl_dq_oe
);
   logic [7:0] rlow_q;
   logic [7:0] rlow_d;

   always_comb rlow_d = o_fl_reset_n ? 8'h00 : rlow_q + 8'h01;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) rlow_q <= 8'h00;
      else rlow_q <= rlow_d;
   end

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   no_fight_a: assert property (!(!o_fl_oe_n && !o_fl_we_n))
      else $error("read and write strobes low together");
   read_strobe_a: assert property ($fell(o_fl_oe_n) |-> !o_fl_ce_n && o_fl_we_n)
      else $error("read without select");
   read_float_a: assert property (!o_fl_oe_n |-> o_fl_dq_oe[14:0] == 15'h0000)
      else $error("controller drives bus during read");
   wr_strobe_a: assert property ($fell(o_fl_we_n) |-> !o_fl_ce_n && o_fl_oe_n)
      else $error("write strobe without select");
   wr_pulse_a: assert property ($fell(o_fl_we_n) |-> !o_fl_we_n [*4] ##1 o_fl_we_n)
      else $error("write pulse width wrong");
   addr_hold_a: assert property (!o_fl_we_n ##1 1'b1 |-> $stable(o_fl_addr))
      else $error("address moved in write");
   data_hold_a: assert property (!o_fl_we_n ##1 1'b1 |-> $stable(o_fl_dq) && &o_fl_dq_oe[7:0])
      else $error("write data moved");
   byte_lane_a: assert property (!o_fl_word |-> o_fl_dq_oe[14:8] == 7'h00)
      else $error("upper lane driven in byte mode");
   rst_float_a: assert property (!o_fl_reset_n |-> o_fl_ce_n && o_fl_oe_n && o_fl_we_n)
      else $error("strobes active in flash reset");
   rst_width_a: assert property ($rose(o_fl_reset_n) |-> rlow_q >= RST_LOW_CYC)
      else $error("flash reset pulse too short");
endmodule : pfcec_top_properties

bind pfcec_top pfcec_top_properties u_pfcec_top_properties (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .o_fl_addr(o_fl_addr), .o_fl_ce_n(o_fl_ce_n),
   .o_fl_oe_n(o_fl_oe_n), .o_fl_we_n(o_fl_we_n), .o_fl_reset_n(o_fl_reset_n),
   .o_fl_word(o_fl_word), .o_fl_dq(o_fl_dq), .o_fl_dq_oe(o_fl_dq_oe));

// >>> tb/pfcec_top_tb.sv
/*
 * Self-checking bench for the flash controller.
 * Assumes the flash model and the bound checker.
 */
`timescale 1ns/100ps
module pfcec_top_tb;
   import pfcec_pkg::*;
   logic        i_clk_sys, i_rst, avs_read, avs_write, avs_wait;
   logic [3:0]  avs_addr;
   logic [31:0] avs_wdata, avs_rdata, st, q;
   logic [19:0] fl_addr, a;
   logic        ce_n, oe_n, we_n, rst_n, word, vpp, rdy;
   logic [15:0] dq, dq_oe, m_dq, m_oe, dq_bus, d, d2;
   int          num_errors, n_tests, seed, cyc;

   assign dq_bus = (dq_oe & dq) | (~dq_oe & m_dq);

   pfcec_top u_pfcec_top (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_avs_address(avs_addr),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_wdata),
      .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait), .o_fl_addr(fl_addr),
      .o_fl_ce_n(ce_n), .o_fl_oe_n(oe_n), .o_fl_we_n(we_n), .o_fl_reset_n(rst_n),
      .o_fl_word(word), .o_fl_vpp_en(vpp), .o_fl_dq(dq), .o_fl_dq_oe(dq_oe),
      .i_fl_dq(dq_bus), .i_fl_ready(rdy));
   pfcec_flash_model u_pfcec_flash_model (.i_addr(fl_addr), .i_ce_n(ce_n), .i_oe_n(oe_n),
      .i_we_n(we_n), .i_reset_n(rst_n), .i_word(word), .i_vpp_en(vpp), .i_dq(dq_bus),
      .o_dq(m_dq), .o_dq_oe(m_oe), .o_ready(rdy));

   task automatic test_done;
      if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
      @(posedge i_clk_sys);
      avs_addr <= ad;
      avs_wdata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge i_clk_sys);
      while (avs_wait !== 1'b0) @(posedge i_clk_sys);
      q = avs_rdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   function automatic logic [31:0] ctrl(input logic [3:0] o, input logic w, input logic v);
      ctrl = 32'h0;
      ctrl[CTRL_OP_LSB +: CTRL_OP_W] = o;
      ctrl[CTRL_WORD_BIT] = w;
      ctrl[CTRL_VPP_BIT] = v;
      ctrl[CTRL_GO_BIT] = 1'b1;
   endfunction : ctrl

   function automatic logic [15:0] exp_prog(input logic [15:0] old, input logic [15:0] nw);
      return old & nw;
   endfunction : exp_prog

   // Run one operation and wait until both controller and flash are idle
   task automatic op(input logic [3:0] o, input logic [19:0] ad, input logic [15:0] wd,
                     input logic w = 1'b1, input logic v = 1'b1);
      bus(1'b1, REG_ADDR, {12'h000, ad});
      bus(1'b1, REG_WDATA, {16'h0000, wd});
      bus(1'b1, REG_CTRL, ctrl(o, w, v));
      repeat (2) do bus(1'b0, REG_STATUS, 32'h0); while (q[STAT_BUSY_BIT] !== 1'b0 || q[STAT_RDY_BIT] !== 1'b1);
      st = q;
   endtask : op

   initial begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         test_done();
      end
   end

   initial begin
      {num_errors, n_tests, cyc} = '0;
      seed = 1;
      i_rst = 1'b1;
      {avs_read, avs_write, avs_addr, avs_wdata} = '0;
      repeat (8) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      bus(1'b0, 4'h2, 32'h0);
      chk(q, 32'h0);
      op(OP_READ, UNLOCK_A1, 16'h0);
      chk(st[STAT_SPM_BIT], 1'b0);
      chk(st[15:0], 16'hffff);
      for (int i = 0; i < 4; i++) begin
         a = 20'($random(seed)) | 20'h80000;
         d = 16'($random(seed));
         op(OP_PROGRAM, a, d);
         op(OP_READ, a, 16'h0);
         chk(st[15:0], d);
      end
      d2 = 16'($random(seed));
      op(OP_PROGRAM, a, d2);
      op(OP_READ, a, 16'h0);
      chk(st[15:0], exp_prog(d, d2));
      op(OP_READ, UNLOCK_A2, 16'h0);
      chk(st[15:0], 16'hffff);
      op(OP_PROGRAM, 20'h00100, 16'h0000, 1'b1, 1'b0);
      op(OP_READ, 20'h00100, 16'h0);
      chk(st[15:0], 16'hffff);
      op(OP_PROGRAM, 20'h01010, 16'h0f0f);
      op(OP_PROGRAM, 20'h02010, 16'h0f0f);
      op(OP_SECT_ERASE, 20'h01010, 16'h0);
      op(OP_READ, 20'h01010, 16'h0);
      chk(st[15:0], 16'hffff);
      op(OP_READ, 20'h04020, 16'h0, 1'b0);
      chk(st[15:0], 16'h000f);
      op(OP_SUSPEND, 20'h0, 16'h0);
      chk(u_pfcec_flash_model.susp_q, 1'b1);
      op(OP_RESUME, 20'h0, 16'h0);
      chk(u_pfcec_flash_model.susp_q, 1'b0);
      op(OP_PROGRAM, 20'hf8000, 16'h1234);
      op(OP_CHIP_ERASE, 20'h0, 16'h0);
      op(OP_READ, 20'h02010, 16'h0);
      chk(st[15:0], 16'hffff);
      op(OP_READ, 20'hf8000, 16'h0);
      chk(st[15:0], 16'h1234);
      op(OP_SPM_ENTER, 20'h0, 16'h0);
      chk(st[STAT_SPM_BIT], 1'b1);
      op(OP_SECT_ERASE, 20'h03000, 16'h5a5a);
      op(OP_SUSPEND, 20'h03100, 16'h00ff);
      op(OP_READ, 20'h03000, 16'h0);
      chk(st[15:0], 16'h5a5a);
      op(OP_READ, 20'h03100, 16'h0);
      chk(st[15:0], 16'h00ff);
      op(OP_RESET, 20'h0, 16'h0);
      chk(st[STAT_SPM_BIT], 1'b0);
      op(OP_RAW_WRITE, 20'h03200, 16'h0000);
      op(OP_READ, 20'h03200, 16'h0);
      chk(st[15:0], 16'hffff);
      test_done();
   end
endmodule : pfcec_top_tb
